// File: rtl/light_timer_pkg.sv
// Purpose : constants for the dual-function light timer
// Assumes : 200 MHz clock, 32-bit bus words
// Notes   : durations are counts of the selected timebase tick
package light_timer_pkg;
    localparam int unsigned CLK_PERIOD_NS = 5;
    localparam int unsigned NS_PER_MS     = 1000000;
    localparam int unsigned CYC_PER_MS    = NS_PER_MS / CLK_PERIOD_NS;
    // selectable timebases, in milliseconds
    localparam int unsigned TB0_MS  = 10;
    localparam int unsigned TB1_MS  = 100;
    localparam int unsigned TB2_MS  = 1000;
    localparam int unsigned TB3_MS  = 10;
    localparam int unsigned TB0_CYC = TB0_MS * CYC_PER_MS;
    localparam int unsigned TB1_CYC = TB1_MS * CYC_PER_MS;
    localparam int unsigned TB2_CYC = TB2_MS * CYC_PER_MS;
    localparam int unsigned TB3_CYC = TB3_MS * CYC_PER_MS;
    // register byte offsets
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_DUR0    = 8'h04;
    localparam logic [7:0] ADDR_STATUS  = 8'h14;
    localparam logic [7:0] ADDR_ELAPSED = 8'h18;
    // control fields
    localparam int CTRL_WARN_BIT = 0;
    localparam int CTRL_RET_BIT  = 1;
    localparam int CTRL_TB_LSB   = 4;
    localparam logic [5:0] CTRL_RESET = 6'h00;
    // duration register fields
    localparam int DUR_W       = 16;
    localparam int DUR_CFG_W   = 20;
    localparam int DUR_EXT_BIT = 16;
    localparam int DUR_BLK_LSB = 17;
    localparam int NUM_DUR     = 4;
    localparam int IDX_OFF     = 0;
    localparam int IDX_HOLD    = 1;
    localparam int IDX_LEAD    = 2;
    localparam int IDX_WLEN    = 3;
    localparam logic [19:0] DUR_RESET = 20'h0_0000;
    localparam int NUM_BLOCKS  = 8;
    // status fields
    localparam int STAT_LAMP_BIT = 0;
    localparam int STAT_PERM_BIT = 1;
    localparam int STAT_ST_LSB   = 2;
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_HOLD  = 2'b01,
        ST_DELAY = 2'b10,
        ST_PERM  = 2'b11
    } light_state_t;
endpackage

// File: rtl/light_timer.sv
// Purpose : dual-function light timer with an AHB-Lite register slave
// Assumes : TRG, STOP and POWER_FAIL are synchronous to REF_CLK
// Notes   : zero-wait slave; read data is sampled in the address phase
//
// The implementer's own choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
module light_timer #(
    parameter int unsigned TB_CYC_0 = light_timer_pkg::TB0_CYC,
    parameter int unsigned TB_CYC_1 = light_timer_pkg::TB1_CYC,
    parameter int unsigned TB_CYC_2 = light_timer_pkg::TB2_CYC,
    parameter int unsigned TB_CYC_3 = light_timer_pkg::TB3_CYC
) (
    // clock and reset
    input  wire logic         REF_CLK,
    input  wire logic         RST_N,
    // AHB-Lite slave
    input  wire logic         HSEL,
    input  wire logic [31:0]  HADDR,
    input  wire logic [1:0]   HTRANS,
    input  wire logic         HWRITE,
    input  wire logic [2:0]   HSIZE,
    input  wire logic [31:0]  HWDATA,
    input  wire logic         HREADY,
    output logic [31:0]       HRDATA,
    output logic              HREADYOUT,
    output logic              HRESP,
    // light control
    input  wire logic         TRG,
    input  wire logic         STOP,
    input  wire logic         POWER_FAIL,
    input  wire logic [127:0] EXT_VALUES,
    output logic              LAMP,
    output logic [15:0]       ELAPSED_TIME
);
    logic [5:0]  ctrl;
    logic [5:0]  next_ctrl;
    logic [19:0] dur_cfg [light_timer_pkg::NUM_DUR];
    logic [19:0] next_dur_cfg [light_timer_pkg::NUM_DUR];
    logic        wr_pend;
    logic        next_wr_pend;
    logic [7:0]  wr_addr;
    logic [7:0]  next_wr_addr;
    logic [31:0] next_hrdata;
    light_timer_pkg::light_state_t state;
    light_timer_pkg::light_state_t next_state;
    logic        next_lamp;
    logic [15:0] elapsed;
    logic [15:0] next_elapsed;
    logic        trg_q;
    logic [31:0] div_cnt;
    logic [31:0] next_div_cnt;
    logic [31:0] div_max;
    logic        tick;
    logic        rise;
    logic        kill;
    logic        warn_en;
    logic        retain;
    logic [15:0] t_off;
    logic [15:0] t_hold;
    logic [15:0] t_lead;
    logic [15:0] t_wlen;
    logic [15:0] warn_start;
    logic [16:0] warn_end;
    logic        in_warn;

    // duration source: constant field or a block's live value
    function automatic logic [15:0] dur_value(input logic [19:0] cfg,
                                              input logic [127:0] ext);
        logic [2:0] blk;
        blk = cfg[light_timer_pkg::DUR_BLK_LSB +: 3];
        if (cfg[light_timer_pkg::DUR_EXT_BIT]) begin
            dur_value = ext[blk * light_timer_pkg::DUR_W +: 16];
        end else begin
            dur_value = cfg[15:0];
        end
    endfunction

    function automatic logic [31:0] rd_value(input logic [7:0] a);
        logic [7:0] d;
        rd_value = 32'h0000_0000;
        d = a - light_timer_pkg::ADDR_DUR0;
        if (a == light_timer_pkg::ADDR_CTRL) begin
            rd_value = {26'h000_0000, ctrl};
        end else if (a >= light_timer_pkg::ADDR_DUR0 &&
                     a < light_timer_pkg::ADDR_STATUS) begin
            rd_value = {12'h000, dur_cfg[d[3:2]]};
        end else if (a == light_timer_pkg::ADDR_STATUS) begin
            rd_value[light_timer_pkg::STAT_LAMP_BIT] = LAMP;
            rd_value[light_timer_pkg::STAT_PERM_BIT] =
                (state == light_timer_pkg::ST_PERM);
            rd_value[light_timer_pkg::STAT_ST_LSB +: 2] = state;
        end else if (a == light_timer_pkg::ADDR_ELAPSED) begin
            rd_value = {16'h0000, elapsed};
        end
    endfunction

    assign HREADYOUT = 1'b1;
    assign HRESP     = 1'b0;

    // bus group: write lands in the data phase, read data is registered
    always_comb begin
        logic [7:0] d;
        d = HADDR[7:0] - light_timer_pkg::ADDR_DUR0;
        next_ctrl    = ctrl;
        next_dur_cfg = dur_cfg;
        next_hrdata  = HRDATA;
        next_wr_pend = 1'b0;
        next_wr_addr = wr_addr;
        if (wr_pend) begin
            d = wr_addr - light_timer_pkg::ADDR_DUR0;
            if (wr_addr == light_timer_pkg::ADDR_CTRL) begin
                next_ctrl = HWDATA[5:0];
            end else if (wr_addr >= light_timer_pkg::ADDR_DUR0 &&
                         wr_addr < light_timer_pkg::ADDR_STATUS) begin
                next_dur_cfg[d[3:2]] = HWDATA[19:0];
            end
        end
        if (HSEL && HTRANS[1] && HREADY) begin
            next_wr_pend = HWRITE && (HADDR[31:8] == 24'h00_0000);
            next_wr_addr = HADDR[7:0];
            next_hrdata  = (HADDR[31:8] == 24'h00_0000) ?
                           rd_value(HADDR[7:0]) : 32'h0000_0000;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            ctrl    <= light_timer_pkg::CTRL_RESET;
            dur_cfg <= '{default: light_timer_pkg::DUR_RESET};
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            HRDATA  <= 32'h0000_0000;
        end else begin
            ctrl    <= next_ctrl;
            dur_cfg <= next_dur_cfg;
            wr_pend <= next_wr_pend;
            wr_addr <= next_wr_addr;
            HRDATA  <= next_hrdata;
        end
    end

    always_comb begin
        unique case (ctrl[light_timer_pkg::CTRL_TB_LSB +: 2])
            2'd0: div_max = TB_CYC_0 - 32'd1;
            2'd1: div_max = TB_CYC_1 - 32'd1;
            2'd2: div_max = TB_CYC_2 - 32'd1;
            2'd3: div_max = TB_CYC_3 - 32'd1;
        endcase
        tick         = (div_cnt >= div_max);
        next_div_cnt = tick ? 32'h0000_0000 : div_cnt + 32'd1;
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            div_cnt <= 32'h0000_0000;
        end else begin
            div_cnt <= next_div_cnt;
        end
    end

    // one timebase field serves every duration
    assign t_off   = dur_value(dur_cfg[light_timer_pkg::IDX_OFF], EXT_VALUES);
    assign t_hold  = dur_value(dur_cfg[light_timer_pkg::IDX_HOLD], EXT_VALUES);
    assign t_lead  = dur_value(dur_cfg[light_timer_pkg::IDX_LEAD], EXT_VALUES);
    assign t_wlen  = dur_value(dur_cfg[light_timer_pkg::IDX_WLEN], EXT_VALUES);
    assign warn_en = ctrl[light_timer_pkg::CTRL_WARN_BIT];
    assign retain  = ctrl[light_timer_pkg::CTRL_RET_BIT];
    assign rise    = TRG && !trg_q;
    // a lead longer than the delay starts the warning at once
    assign warn_start = (t_off > t_lead) ? t_off - t_lead : 16'h0000;
    assign warn_end   = {1'b0, warn_start} + {1'b0, t_wlen};
    assign in_warn    = warn_en && (elapsed >= warn_start) &&
                        ({1'b0, elapsed} < warn_end);
    // stop, or power loss without retention, clears the state, LAMP and the elapsed count
    assign kill = STOP || (POWER_FAIL && !retain);

    // timer group
    always_comb begin
        next_state   = state;
        next_lamp    = LAMP;
        next_elapsed = elapsed;
        if (kill) begin
            next_state   = light_timer_pkg::ST_IDLE;
            next_lamp    = 1'b0;
            next_elapsed = 16'h0000;
        end else begin
            unique case (state)
                light_timer_pkg::ST_IDLE: begin
                    if (rise) begin
                        next_state   = light_timer_pkg::ST_HOLD;
                        next_lamp    = 1'b1;
                        next_elapsed = 16'h0000;
                    end
                end
                light_timer_pkg::ST_HOLD: begin
                    if (!TRG) begin
                        next_state   = light_timer_pkg::ST_DELAY;
                        next_elapsed = 16'h0000;
                    end else if (elapsed >= t_hold) begin
                        next_state = light_timer_pkg::ST_PERM;
                    end else if (tick) begin
                        next_elapsed = elapsed + 16'd1;
                    end
                end
                light_timer_pkg::ST_DELAY: begin
                    if (rise || elapsed >= t_off) begin
                        next_state   = light_timer_pkg::ST_IDLE;
                        next_lamp    = 1'b0;
                        next_elapsed = 16'h0000;
                    end else begin
                        next_lamp = !in_warn;
                        if (tick) begin
                            next_elapsed = elapsed + 16'd1;
                        end
                    end
                end
                light_timer_pkg::ST_PERM: begin
                    if (rise) begin
                        next_state   = light_timer_pkg::ST_IDLE;
                        next_lamp    = 1'b0;
                        next_elapsed = 16'h0000;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            state   <= light_timer_pkg::ST_IDLE;
            LAMP    <= 1'b0;
            elapsed <= 16'h0000;
            trg_q   <= 1'b0;
        end else begin
            state   <= next_state;
            LAMP    <= next_lamp;
            elapsed <= next_elapsed;
            trg_q   <= TRG;
        end
    end

    assign ELAPSED_TIME = elapsed;

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);

    sequence s_short_press;
        state == light_timer_pkg::ST_HOLD && TRG
        ##1 state == light_timer_pkg::ST_HOLD && !TRG && !kill;
    endsequence
    sequence s_lamp_off_idle;
        !LAMP && state == light_timer_pkg::ST_IDLE && elapsed == 16'h0000;
    endsequence

    property p_rise_on;
        state == light_timer_pkg::ST_IDLE && rise && !kill |=> LAMP;
    endproperty
    a_rise_on: assert property (p_rise_on) else $error("lamp not on");
    property p_perm;
        state == light_timer_pkg::ST_HOLD && TRG && elapsed >= t_hold && !kill
        |=> state == light_timer_pkg::ST_PERM && LAMP;
    endproperty
    a_perm: assert property (p_perm) else $error("no permanent");
    property p_delay_start;
        s_short_press |=> state == light_timer_pkg::ST_DELAY &&
                          elapsed == 16'h0000 && LAMP;
    endproperty
    a_delay_start: assert property (p_delay_start) else $error("no delay");
    property p_expire;
        state == light_timer_pkg::ST_DELAY && elapsed >= t_off && !kill
        |=> s_lamp_off_idle;
    endproperty
    a_expire: assert property (p_expire) else $error("no expiry");
    property p_warn;
        state == light_timer_pkg::ST_DELAY && !kill && !rise &&
        elapsed < t_off && in_warn |=> !LAMP;
    endproperty
    a_warn: assert property (p_warn) else $error("no warning gap");
    property p_retrig;
        (state == light_timer_pkg::ST_DELAY ||
         state == light_timer_pkg::ST_PERM) && rise |=> s_lamp_off_idle;
    endproperty
    a_retrig: assert property (p_retrig) else $error("retrigger kept");
    property p_stop;
        STOP |=> s_lamp_off_idle;
    endproperty
    a_stop: assert property (p_stop) else $error("stop ignored");
    property p_power;
        POWER_FAIL && !retain |=> !LAMP && ELAPSED_TIME == 16'h0000;
    endproperty
    a_power: assert property (p_power) else $error("power loss kept");
    property p_tick;
        state == light_timer_pkg::ST_HOLD && TRG && tick &&
        elapsed < t_hold && !kill |=> elapsed == $past(elapsed) + 16'd1;
    endproperty
    a_tick: assert property (p_tick) else $error("count not advanced");
endmodule

// File: verification/ext_block_model.sv
// Purpose : stands in for the other function blocks' live values
// Assumes : the values stay put for the whole run
// Notes   : block n carries 4 * (n + 1), so each block is distinct
`timescale 1ns/1ps
module ext_block_model (
    // live values, block n in bits [16n+15:16n]
    output logic [127:0] VALUES
);
    always_comb begin
        for (int n = 0; n < light_timer_pkg::NUM_BLOCKS; n++) begin
            VALUES[16*n +: 16] = 16'(4 * (n + 1));
        end
    end
endmodule

// File: verification/light_timer_tb_top.sv
// Purpose : self-checking bench for the dual-function light timer
// Assumes : short timebases 4, 8, 16 and 1 cycles per tick
// Notes   : expiry counts allow up to one tick period of phase
`timescale 1ns/1ps
module light_timer_tb_top;
    logic         ref_clk = 1'b0;
    logic         rst_n   = 1'b0;
    logic [1:0]   htrans  = 2'h0;
    logic         hsel    = 1'b0;
    logic [2:0]   hsize   = 3'h0;
    logic         hresp;
    logic         hwrite  = 1'b0;
    logic [31:0]  haddr   = 32'h0000_0000;
    logic [31:0]  hwdata  = 32'h0000_0000;
    logic [31:0]  hrdata;
    logic         hreadyout;
    logic         trg     = 1'b0;
    logic         stop    = 1'b0;
    logic         pfail   = 1'b0;
    logic [127:0] ext_values;
    logic         lamp;
    logic [15:0]  elapsed_time;
    int           n_errors = 0;
    int           check_count = 0;

    always #2.5 ref_clk = ~ref_clk;

    ext_block_model u_ext_block_model (.VALUES(ext_values));

    light_timer #(.TB_CYC_0(4), .TB_CYC_1(8), .TB_CYC_2(16), .TB_CYC_3(1))
    u_light_timer (
        .REF_CLK(ref_clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
        .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
        .HRESP(hresp), .TRG(trg), .STOP(stop), .POWER_FAIL(pfail),
        .EXT_VALUES(ext_values), .LAMP(lamp), .ELAPSED_TIME(elapsed_time)
    );

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // an unknown value never counts as inside the range
    task automatic chk_rng(input logic [31:0] got, input int lo,
                           input int hi);
        check_count++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask

    // single AHB-Lite transfer; read data taken at the data-phase edge
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge ref_clk);
        hsel   <= 1'b1;
        hsize  <= 3'h2;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr  <= {24'h00_0000, a};
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) @(posedge ref_clk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) @(posedge ref_clk);
        q = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, q);
        chk(q, e);
    endtask

    task automatic dur(input int idx, input logic [31:0] d);
        wr(8'(light_timer_pkg::ADDR_DUR0 + 4 * idx), d);
    endtask

    task automatic press(input int n);
        @(posedge ref_clk);
        trg <= 1'b1;
        repeat (n) @(posedge ref_clk);
        trg <= 1'b0;
    endtask

    task automatic cnt_on(output int n);
        n = 0;
        while (lamp === 1'b1 && n < 200) begin
            @(posedge ref_clk);
            n++;
        end
    endtask

    task automatic clear_pulse(input logic use_stop);
        repeat (5) @(posedge ref_clk);
        stop  <= use_stop;
        pfail <= !use_stop;
        @(posedge ref_clk);
        stop  <= 1'b0;
        pfail <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic t_reset();
        rd(light_timer_pkg::ADDR_CTRL, 32'h0000_0000);
        for (int i = 0; i < 4; i++) begin
            rd(8'(light_timer_pkg::ADDR_DUR0 + 4 * i), 32'h0000_0000);
        end
        rd(light_timer_pkg::ADDR_STATUS, 32'h0000_0000);
        wr(8'hFC, 32'hFFFF_FFFF);
        rd(8'hFC, 32'h0000_0000);
        chk({31'h0, hresp}, 32'h0000_0000);
        chk({31'h0, lamp}, 32'h0000_0000);
        $display("test reset done");
    endtask

    task automatic t_short();
        int n;
        wr(light_timer_pkg::ADDR_CTRL, 32'h0000_0030);
        dur(0, 32'h0000_000A);
        dur(1, 32'h0000_0064);
        press(2);
        chk({31'h0, lamp}, 32'h0000_0001);
        cnt_on(n);
        chk_rng(n, 10, 13);
        chk({16'h0, elapsed_time}, 32'h0000_0000);
        repeat (5) @(posedge ref_clk);
        chk({31'h0, lamp}, 32'h0000_0000);
        $display("test short press done");
    endtask

    task automatic t_perm();
        dur(1, 32'h0000_0005);
        @(posedge ref_clk);
        trg <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk_rng({16'h0, elapsed_time}, 1, 3);
        repeat (10) @(posedge ref_clk);
        trg <= 1'b0;
        repeat (30) @(posedge ref_clk);
        chk({31'h0, lamp}, 32'h0000_0001);
        rd(light_timer_pkg::ADDR_STATUS, 32'h0000_000F);
        rd(light_timer_pkg::ADDR_ELAPSED, 32'h0000_0005);
        press(1);
        repeat (3) @(posedge ref_clk);
        chk({31'h0, lamp}, 32'h0000_0000);
        $display("test permanent done");
    endtask

    task automatic t_clear();
        dur(0, 32'h0000_0032);
        press(2);
        repeat (5) @(posedge ref_clk);
        press(1);
        repeat (2) @(posedge ref_clk);
        chk({31'h0, lamp}, 32'h0000_0000);
        press(2);
        clear_pulse(1'b1);
        chk({15'h0, lamp, elapsed_time}, 32'h0000_0000);
        press(2);
        clear_pulse(1'b0);
        chk({15'h0, lamp, elapsed_time}, 32'h0000_0000);
        wr(light_timer_pkg::ADDR_CTRL, 32'h0000_0032);
        press(2);
        clear_pulse(1'b0);
        chk({31'h0, lamp}, 32'h0000_0001);
        chk_rng({16'h0, elapsed_time}, 4, 9);
        // leave the timer idle so the next press switches on
        clear_pulse(1'b1);
        chk({15'h0, lamp, elapsed_time}, 32'h0000_0000);
        $display("test clear done");
    endtask

    task automatic t_warn();
        int z;
        int n;
        z = 0;
        wr(light_timer_pkg::ADDR_CTRL, 32'h0000_0031);
        dur(0, 32'h0000_0014);
        dur(2, 32'h0000_000A);
        dur(3, 32'h0000_0004);
        press(2);
        for (int i = 0; i < 18; i++) begin
            @(posedge ref_clk);
            if (lamp !== 1'b1) z++;
        end
        chk_rng(z, 3, 5);
        chk({31'h0, lamp}, 32'h0000_0001);
        cnt_on(n);
        chk_rng(n, 1, 6);
        $display("test warning done");
    endtask

    task automatic t_ext();
        int n;
        wr(light_timer_pkg::ADDR_CTRL, 32'h0000_0000);
        dur(0, 32'h0003_0000);
        press(2);
        cnt_on(n);
        chk_rng(n, 30, 40);
        wr(light_timer_pkg::ADDR_CTRL, 32'h0000_0020);
        dur(0, 32'h0000_0004);
        press(2);
        cnt_on(n);
        chk_rng(n, 52, 67);
        $display("test timebase done");
    endtask

    initial begin
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        t_reset();
        t_short();
        t_perm();
        t_clear();
        t_warn();
        t_ext();
        give_verdict();
    end

    // whole run is a few hundred cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_errors++;
        give_verdict();
    end
endmodule
